// file: logic/sbf_defs.svh
`ifndef SBF_DEFS_SVH
`define SBF_DEFS_SVH

// register byte offsets
`define SBF_OFS_CFG1   8'h00
`define SBF_OFS_CFG2   8'h04
`define SBF_OFS_MASK1  8'h08
`define SBF_OFS_MASK2  8'h0c
`define SBF_OFS_QPTR   8'h10
`define SBF_OFS_DPTR   8'h14
`define SBF_OFS_TTAG   8'h18
`define SBF_OFS_LCMD   8'h1c
`define SBF_OFS_TSTAT  8'h20
`define SBF_OFS_FLAGS  8'h24

// reset values
`define SBF_CFG1_RST   4'h0
`define SBF_CFG2_RST   16'h0000
`define SBF_MASK1_RST  16'h0000
`define SBF_MASK2_RST  5'h00
`define SBF_QPTR_RST   16'h0000
`define SBF_DPTR_RST   8'h00

// field positions
`define SBF_CFG1_SOE   2
`define SBF_CFG1_CIRC  3
`define SBF_CFG2_AREA  0
`define SBF_CFG2_TTRUN 4
`define SBF_BSW_ERR    12
`define SBF_FLG_BUSY   0
`define SBF_FLG_STOP   1
`define SBF_FLG_OVR    2

// memory areas and stack sizes
`define SBF_AREA_A_BASE 16'h0100
`define SBF_AREA_B_BASE 16'h0f00
`define SBF_DSTK_SMALL  8'h3f
`define SBF_DSTK_LARGE  8'hff

// time tag base resolution
`define SBF_CLK_NS      20
`define SBF_TT_BASE_NS  2000
`define SBF_TT_BASE_CYC (`SBF_TT_BASE_NS / `SBF_CLK_NS)

`endif

// file: logic/sbf_pkg.sv
package sbf_pkg;

   typedef enum logic [1:0] {SBF_MODE_BC, SBF_MODE_RT, SBF_MODE_MM, SBF_MODE_WM} sbf_mode_t;

   typedef struct packed {
      logic       status_set, fmt_err, no_resp, loop_fail, masked_set;
      logic [1:0] retry;
      logic       good_block, wrong_addr, wc_err, sync_err, inv_word;
      logic       rtrt_fmt, rollover, illegal, rtrt_gap, rtrt_2nd, cmd_err;
   } sbf_msg_flags_t;

   typedef struct packed {
      logic [7:0] gap;
      logic       word_flag, this_rt, bcast, err, is_cmd, chan_b, contig, mode_code;
   } sbf_wm_id_t;

   typedef struct packed {
      logic msg;
      logic tx_timeout, illegal, mdat_half, mdat_full, rtcb_half, rtcb_full;
      logic mdsc_half, mdsc_full, rtdsc_half, rtdsc_full, handshake, fmt_err;
      logic mode_int, sa_end, message_end_flag;
      logic tt_roll, addr_par, selftest_done, ram_par;
   } sbf_irq_evt_t;

   typedef struct packed {
      logic [4:0] rt_addr;
      logic       tx;
      logic [4:0] subaddr;
      logic [4:0] count;
   } sbf_cmd_t;

   typedef struct packed {
      logic [4:0] rt_addr;
      logic       msg_err, instr, svc_req;
      logic [2:0] rsvd;
      logic       bcast, busy, subsystem_fault_flag, dbca, term_flag;
   } sbf_term_status_t;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [15:0] data;
   } sbf_mem_wr_t;

endpackage

// file: logic/sbf_fmt.sv
`timescale 1ns/1ps
`default_nettype none

// packs block status, identification and queue words for the current mode
module sbf_fmt
   import sbf_pkg::*;
(
   input  wire sbf_mode_t      mode,
   input  wire logic           begin_flag,
   input  wire logic           end_flag,
   input  wire logic           chan_b,
   input  wire sbf_msg_flags_t fl,
   input  wire sbf_wm_id_t     wm,
   input  wire sbf_irq_evt_t   ev,
   output logic [15:0]         bsw,
   output logic [15:0]         idw,
   output logic [15:0]         qent
);
   logic err;

   always_comb begin
      err = fl.fmt_err | fl.no_resp | fl.loop_fail | fl.wc_err | fl.sync_err | fl.inv_word;
      case (mode)
         SBF_MODE_BC: bsw = {end_flag, begin_flag, chan_b, err | fl.wrong_addr, fl.status_set,
                             fl.fmt_err, fl.no_resp, fl.loop_fail, fl.masked_set, fl.retry,
                             fl.good_block, fl.wrong_addr, fl.wc_err, fl.sync_err,
                             fl.inv_word};
         SBF_MODE_RT: bsw = {end_flag, begin_flag, chan_b, err | fl.illegal, fl.rtrt_fmt,
                             fl.fmt_err, fl.no_resp, fl.loop_fail, fl.rollover, fl.illegal,
                             fl.wc_err, fl.sync_err, fl.inv_word, fl.rtrt_gap, fl.rtrt_2nd,
                             fl.cmd_err};
         SBF_MODE_MM: bsw = {end_flag, begin_flag, chan_b, err, fl.rtrt_fmt, fl.fmt_err,
                             fl.no_resp, fl.good_block, fl.rollover, 1'b0, fl.wc_err,
                             fl.sync_err, fl.inv_word, fl.rtrt_gap, fl.rtrt_2nd,
                             fl.cmd_err};
         default:     bsw = 16'h0000;
      endcase
      idw = {wm.gap, wm.word_flag, wm.this_rt, wm.bcast, wm.err, wm.is_cmd, chan_b,
             wm.contig, wm.mode_code};
      if (ev.msg) begin
         qent = {ev.tx_timeout, ev.illegal, ev.mdat_half, ev.mdat_full, ev.rtcb_half,
                 ev.rtcb_full, ev.mdsc_half, ev.mdsc_full, ev.rtdsc_half, ev.rtdsc_full,
                 ev.handshake, ev.fmt_err, ev.mode_int, ev.sa_end, ev.message_end_flag,
                 1'b1};
      end else begin
         qent = {11'h000, ev.tt_roll, ev.addr_par, ev.selftest_done, ev.ram_par,
                 1'b0};
      end
   end
endmodule // sbf_fmt

`default_nettype wire

// file: logic/sbf_cmd_dec.sv
`timescale 1ns/1ps
`default_nettype none

// splits a bus command word and builds this terminal's status word
module sbf_cmd_dec
   import sbf_pkg::*;
(
   input  wire logic [15:0] cmd_word,
   input  wire logic [15:0] cfg2,
   input  wire logic        msg_err,
   output sbf_cmd_t         cmd,
   output logic             is_mode,
   output logic [15:0]      tstat
);
   sbf_term_status_t ts;

   always_comb begin
      cmd     = sbf_cmd_t'(cmd_word);
      // subaddress 0 or 31 turns the count field into a mode code
      is_mode = (cmd.subaddr == 5'h00) || (cmd.subaddr == 5'h1f);
      ts.rt_addr              = cfg2[9:5];
      ts.msg_err              = msg_err;
      ts.instr                = cfg2[14];
      ts.svc_req              = cfg2[10];
      ts.rsvd                 = 3'h0;
      ts.bcast                = (cmd.rt_addr == 5'h1f);
      ts.busy                 = cfg2[11];
      ts.subsystem_fault_flag = cfg2[12];
      ts.dbca                 = cfg2[13];
      ts.term_flag            = cfg2[15];
      tstat = ts;
   end
endmodule // sbf_cmd_dec

`default_nettype wire

// file: logic/sbf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbf_defs.svh"

module sbf_top
   import sbf_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic [7:0]     paddr,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [31:0]    pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire logic           msg_begin,
   input  wire logic [15:0]    msg_cmd,
   input  wire logic           msg_chan_b,
   input  wire logic           msg_end,
   input  wire sbf_msg_flags_t msg_flags,
   input  wire logic           wm_valid,
   input  wire logic [15:0]    wm_data,
   input  wire sbf_wm_id_t     wm_id,
   input  wire logic           irq_valid,
   input  wire sbf_irq_evt_t   irq_evt,
   output sbf_mem_wr_t         mem_wr,
   output logic [15:0]         term_status
);
   typedef enum {ST_IDLE, ST_BEG_STAT, ST_BEG_TAG, ST_BEG_CMD,
                 ST_END_STAT, ST_END_TAG, ST_WM_DATA, ST_WM_ID, ST_QUEUE} sbf_state_t;

   sbf_state_t     state_reg;
   sbf_state_t     state_next;
   logic [31:0]    prdata_reg;
   logic [31:0]    rd_next;
   logic           pready_reg;
   logic           pslverr_reg;
   logic [3:0]     cfg1_reg;
   logic [15:0]    cfg2_reg;
   logic [15:0]    mask1_reg;
   logic [4:0]     mask2_reg;
   logic [15:0]    qptr_reg;
   logic [7:0]     dptr_reg;
   logic [15:0]    ttag_reg;
   logic [11:0]    tdiv_reg;
   logic           tick;
   logic [15:0]    lcmd_reg;
   logic           stopped_reg;
   logic           overrun_reg;
   logic           msg_err_reg;
   logic           pend_beg_reg;
   logic           pend_end_reg;
   logic           pend_wm_reg;
   logic           pend_q_reg;
   logic           beg_chan_reg;
   logic           end_chan_reg;
   logic [15:0]    beg_cmd_reg;
   sbf_msg_flags_t end_flags_reg;
   logic [15:0]    wm_data_reg;
   sbf_wm_id_t     wm_id_reg;
   sbf_irq_evt_t   q_evt_reg;
   sbf_mem_wr_t    mem_reg;
   sbf_mem_wr_t    mem_next;
   logic [15:0]    tstat_reg;
   logic [15:0]    tstat_w;
   logic [15:0]    bsw_w;
   logic [15:0]    idw_w;
   logic [15:0]    qent_w;
   sbf_cmd_t       cmd_w;
   logic           is_mode_w;
   logic           in_end;
   logic           wr_acc;
   logic           clr_beg;
   logic           clr_end;
   logic           clr_wm;
   logic           clr_q;
   logic           q_ok;
   logic [15:0]    area_base;
   logic [7:0]     dstk_wrap;
   sbf_mode_t      mode;

   function automatic logic reg_known(input logic [7:0] a);
      reg_known = (a[1:0] == 2'b00) && (a <= `SBF_OFS_FLAGS);
   endfunction

   function automatic logic [7:0] dstk_add(input logic [7:0] p, input logic [7:0] n,
                                           input logic [7:0] wrap);
      dstk_add = (p + n) & wrap;
   endfunction

   assign mode      = sbf_mode_t'(cfg1_reg[1:0]);
   assign area_base = cfg2_reg[`SBF_CFG2_AREA] ? `SBF_AREA_B_BASE : `SBF_AREA_A_BASE;
   assign dstk_wrap = cfg1_reg[`SBF_CFG1_CIRC] ? `SBF_DSTK_LARGE : `SBF_DSTK_SMALL;
   assign wr_acc    = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign in_end    = (state_reg == ST_END_STAT);

   sbf_fmt u_fmt (
      .mode       (mode),
      .begin_flag (state_reg == ST_BEG_STAT),
      .end_flag   (in_end),
      .chan_b     (in_end ? end_chan_reg : (state_reg == ST_BEG_STAT ? beg_chan_reg
                                                                     : wm_id_reg.chan_b)),
      .fl         (in_end ? end_flags_reg : sbf_msg_flags_t'(0)),
      .wm         (wm_id_reg),
      .ev         (q_evt_reg),
      .bsw        (bsw_w),
      .idw        (idw_w),
      .qent       (qent_w)
   );

   sbf_cmd_dec u_dec (
      .cmd_word (lcmd_reg),
      .cfg2     (cfg2_reg),
      .msg_err  (msg_err_reg),
      .cmd      (cmd_w),
      .is_mode  (is_mode_w),
      .tstat    (tstat_w)
   );

   // register read mux
   always_comb begin
      rd_next = 32'h0000_0000;
      if (paddr == `SBF_OFS_CFG1) begin
         rd_next[3:0] = cfg1_reg;
      end else if (paddr == `SBF_OFS_CFG2) begin
         rd_next[15:0] = cfg2_reg;
      end else if (paddr == `SBF_OFS_MASK1) begin
         rd_next[15:0] = mask1_reg;
      end else if (paddr == `SBF_OFS_MASK2) begin
         rd_next[4:0] = mask2_reg;
      end else if (paddr == `SBF_OFS_QPTR) begin
         rd_next[15:0] = qptr_reg;
      end else if (paddr == `SBF_OFS_DPTR) begin
         rd_next[7:0] = dptr_reg;
      end else if (paddr == `SBF_OFS_TTAG) begin
         rd_next[15:0] = ttag_reg;
      end else if (paddr == `SBF_OFS_LCMD) begin
         rd_next[15:0] = lcmd_reg;
         rd_next[16]   = is_mode_w;
      end else if (paddr == `SBF_OFS_TSTAT) begin
         rd_next[15:0] = tstat_reg;
      end else if (paddr == `SBF_OFS_FLAGS) begin
         rd_next[`SBF_FLG_BUSY] = (state_reg != ST_IDLE);
         rd_next[`SBF_FLG_STOP] = stopped_reg;
         rd_next[`SBF_FLG_OVR]  = overrun_reg;
      end
   end

   // answer in the first access cycle; unmapped or unaligned offsets give pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready_reg  <= 1'b1;
         pslverr_reg <= !reg_known(paddr);
         prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
      end else begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // configuration and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg1_reg  <= `SBF_CFG1_RST;
         cfg2_reg  <= `SBF_CFG2_RST;
         mask1_reg <= `SBF_MASK1_RST;
         mask2_reg <= `SBF_MASK2_RST;
      end else if (wr_acc) begin
         if (paddr == `SBF_OFS_CFG1) begin
            cfg1_reg <= pwdata[3:0];
         end else if (paddr == `SBF_OFS_CFG2) begin
            cfg2_reg <= pwdata[15:0];
         end else if (paddr == `SBF_OFS_MASK1) begin
            mask1_reg <= {pwdata[15:1], 1'b0};
         end else if (paddr == `SBF_OFS_MASK2) begin
            mask2_reg <= {pwdata[4:1], 1'b0};
         end
      end
   end

   // time tag: base tick scaled by the resolution field, 2 us to 64 us per count for settings 0 to 5; 6 and 7 truncate to 12 bits (2304 and 512 cycles)
   assign tick = (tdiv_reg == 12'((`SBF_TT_BASE_CYC << cfg2_reg[3:1]) - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdiv_reg <= 12'h000;
         ttag_reg <= 16'h0000;
      end else if (!cfg2_reg[`SBF_CFG2_TTRUN]) begin
         tdiv_reg <= 12'h000;
      end else if (tick) begin
         tdiv_reg <= 12'h000;
         ttag_reg <= ttag_reg + 16'h0001;
      end else begin
         tdiv_reg <= tdiv_reg + 12'h001;
      end
   end

   // events are latched; an event in the cycle its pending bit clears is kept
   assign clr_beg = (state_reg == ST_BEG_CMD);
   assign clr_end = (state_reg == ST_END_TAG);
   assign clr_wm  = (state_reg == ST_WM_ID);
   assign clr_q   = (state_reg == ST_QUEUE);
   assign q_ok    = irq_evt.msg ? |(16'(irq_evt[18:4]) & (mask1_reg >> 1))
                                : |({irq_evt[3:0], 1'b0} & mask2_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_beg_reg <= 1'b0;
         beg_cmd_reg  <= 16'h0000;
         beg_chan_reg <= 1'b0;
      end else if (msg_begin && !stopped_reg) begin
         pend_beg_reg <= 1'b1;
         beg_cmd_reg  <= msg_cmd;
         beg_chan_reg <= msg_chan_b;
      end else if (clr_beg) begin
         pend_beg_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_end_reg  <= 1'b0;
         end_flags_reg <= sbf_msg_flags_t'(0);
         end_chan_reg  <= 1'b0;
      end else if (msg_end) begin
         pend_end_reg  <= 1'b1;
         end_flags_reg <= msg_flags;
         end_chan_reg  <= msg_chan_b;
      end else if (clr_end) begin
         pend_end_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_wm_reg <= 1'b0;
         wm_data_reg <= 16'h0000;
         wm_id_reg   <= sbf_wm_id_t'(0);
      end else if (wm_valid && mode == SBF_MODE_WM) begin
         pend_wm_reg <= 1'b1;
         wm_data_reg <= wm_data;
         wm_id_reg   <= wm_id;
      end else if (clr_wm) begin
         pend_wm_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q_reg <= 1'b0;
         q_evt_reg  <= sbf_irq_evt_t'(0);
      end else if (irq_valid && q_ok) begin
         pend_q_reg <= 1'b1;
         q_evt_reg  <= irq_evt;
      end else if (clr_q) begin
         pend_q_reg <= 1'b0;
      end
   end

   // status flags: stop on controller error, overrun when an event arrives while one of its kind is still pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stopped_reg <= 1'b0;
         overrun_reg <= 1'b0;
         msg_err_reg <= 1'b0;
      end else begin
         if (in_end && mode == SBF_MODE_BC && cfg1_reg[`SBF_CFG1_SOE] && bsw_w[`SBF_BSW_ERR]) begin
            stopped_reg <= 1'b1;
         end else if (wr_acc && paddr == `SBF_OFS_FLAGS && pwdata[`SBF_FLG_STOP]) begin
            stopped_reg <= 1'b0;
         end
         if ((msg_begin && pend_beg_reg && !clr_beg) || (msg_end && pend_end_reg && !clr_end) ||
             (wm_valid && pend_wm_reg && !clr_wm) || (irq_valid && pend_q_reg && !clr_q)) begin
            overrun_reg <= 1'b1;
         end else if (wr_acc && paddr == `SBF_OFS_FLAGS && pwdata[`SBF_FLG_OVR]) begin
            overrun_reg <= 1'b0;
         end
         if (in_end && mode == SBF_MODE_RT) begin
            msg_err_reg <= bsw_w[`SBF_BSW_ERR];
         end
      end
   end

   // last command word and the terminal status word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcmd_reg  <= 16'h0000;
         tstat_reg <= 16'h0000;
      end else begin
         if (clr_beg) begin
            lcmd_reg <= beg_cmd_reg;
         end
         tstat_reg <= tstat_w;
      end
   end

   // stack and queue pointers; a software write wins over an advance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dptr_reg <= `SBF_DPTR_RST;
         qptr_reg <= `SBF_QPTR_RST;
      end else begin
         if (wr_acc && paddr == `SBF_OFS_DPTR) begin
            dptr_reg <= pwdata[7:0];
         end else if (clr_end) begin
            dptr_reg <= dstk_add(dptr_reg, 8'h04, dstk_wrap);
         end else if (clr_wm) begin
            dptr_reg <= dstk_add(dptr_reg, 8'h02, dstk_wrap);
         end
         if (wr_acc && paddr == `SBF_OFS_QPTR) begin
            qptr_reg <= pwdata[15:0];
         end else if (clr_q) begin
            qptr_reg <= {qptr_reg[15:6], qptr_reg[5:0] + 6'h01};
         end
      end
   end

   // memory write sequencer, one word per cycle
   always_comb begin
      state_next    = ST_IDLE;
      mem_next.we   = 1'b1;
      mem_next.addr = area_base + 16'(dptr_reg);
      mem_next.data = 16'h0000;
      case (state_reg)
         ST_IDLE: begin
            mem_next.we = 1'b0;
            if (pend_beg_reg) begin
               state_next = ST_BEG_STAT;
            end else if (pend_end_reg) begin
               state_next = ST_END_STAT;
            end else if (pend_wm_reg) begin
               state_next = ST_WM_DATA;
            end else if (pend_q_reg) begin
               state_next = ST_QUEUE;
            end
         end
         ST_BEG_STAT: begin
            state_next    = ST_BEG_TAG;
            mem_next.data = bsw_w;
         end
         ST_BEG_TAG: begin
            state_next    = ST_BEG_CMD;
            mem_next.addr = area_base + 16'(dptr_reg) + 16'h0001;
            mem_next.data = ttag_reg;
         end
         ST_BEG_CMD: begin
            mem_next.addr = area_base + 16'(dptr_reg) + 16'h0003;
            mem_next.data = beg_cmd_reg;
         end
         ST_END_STAT: begin
            state_next    = ST_END_TAG;
            mem_next.data = bsw_w;
         end
         ST_END_TAG: begin
            mem_next.addr = area_base + 16'(dptr_reg) + 16'h0001;
            mem_next.data = ttag_reg;
         end
         ST_WM_DATA: begin
            state_next    = ST_WM_ID;
            mem_next.data = wm_data_reg;
         end
         ST_WM_ID: begin
            mem_next.addr = area_base + 16'(dptr_reg) + 16'h0001;
            mem_next.data = idw_w;
         end
         ST_QUEUE: begin
            mem_next.addr = qptr_reg;
            mem_next.data = qent_w;
         end
         default: begin
            mem_next.we = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_reg <= sbf_mem_wr_t'(0);
      end else begin
         mem_reg <= mem_next;
      end
   end

   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign mem_wr      = mem_reg;
   assign term_status = tstat_reg;

endmodule // sbf_top

`default_nettype wire

// file: bench/sbf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sbf_checker
   import sbf_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        msg_begin,
   input wire logic        msg_end,
   input wire logic        msg_chan_b,
   input wire sbf_mem_wr_t mem_wr,
   input wire logic [15:0] term_status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_stat(logic [1:0] ends);
      ##[2:12] (mem_wr.we && mem_wr.data[15:14] == ends);
   endsequence
   a_ready_answer: assert property (s_setup |=> pready && penable)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready) else $error("ready held");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_read_upper: assert property (pready |-> prdata[31:17] == 15'h0000)
      else $error("upper read bits set");
   a_begin_word: assert property (msg_begin |-> s_stat(2'b01))
      else $error("no begin status word");
   a_end_word: assert property (msg_end |-> s_stat(2'b10))
      else $error("no end status word");
   a_end_chan: assert property (msg_end && msg_chan_b |-> ##[2:12] (mem_wr.we &&
      mem_wr.data[15] && mem_wr.data[13])) else $error("channel bit lost");
   a_tstat_resv: assert property (term_status[7:5] == 3'h0)
      else $error("reserved status bits set");
endmodule // sbf_checker
`default_nettype wire

// file: bench/sbf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// shared memory seen by host software
module sbf_mem_model
   import sbf_pkg::*;
(
   input wire logic        pclk,
   input wire sbf_mem_wr_t mem_wr
);
   logic [15:0] mem [0:65535];
   always @(posedge pclk) begin
      if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
   end
endmodule // sbf_mem_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbf_defs.svh"
module testbench
   import sbf_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic msg_begin = 0, msg_end = 0, msg_chan_b = 0, wm_valid = 0, irq_valid = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] msg_cmd = 16'h1fe2, wm_data = 16'h1fe2, term_status;
   sbf_msg_flags_t msg_flags = '0;
   sbf_wm_id_t wm_id = '0;
   sbf_irq_evt_t irq_evt = '0;
   sbf_mem_wr_t mem_wr;
   int fail_count = 0, compares = 0, cyc = 0;
   logic [19:0] fl [3] = '{20'h01000, 20'h00008, 20'h80400};
   logic [15:0] ex [3] = '{16'h8040, 16'h9040, 16'ha100};
   sbf_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .msg_begin, .msg_cmd, .msg_chan_b, .msg_end, .msg_flags,
      .wm_valid, .wm_data, .wm_id, .irq_valid, .irq_evt, .mem_wr, .term_status);
   sbf_mem_model mem_u (.pclk, .mem_wr);
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   task wrap_up;
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // k: {wm, queue, end, begin}; begin uses bus B, end uses bus B only when v[19] is set
   task fire(input logic [3:0] k, input logic [19:0] v);
      @(posedge pclk);
      {wm_valid, irq_valid, msg_end, msg_begin} <= k;
      msg_chan_b <= k[0] | v[19];
      msg_flags <= sbf_msg_flags_t'(v[17:0]);
      irq_evt <= sbf_irq_evt_t'(v);
      wm_id <= sbf_wm_id_t'(v[15:0]);
      @(posedge pclk);
      {wm_valid, irq_valid, msg_end, msg_begin} <= 4'h0;
      repeat (12) @(posedge pclk);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(`SBF_OFS_CFG1, 0, 0); chk("cfg1", rd, 0);
      apb(8'h3c, 0, 0); chk("unmapped", err, 1);
      apb(`SBF_OFS_CFG2, 1, 32'h0aa0);
      apb(`SBF_OFS_TSTAT, 0, 0);
      chk("tstat", term_status, 16'ha808);
      chk("tstat read", rd, 16'ha808);
      for (int i = 0; i < 3; i++) begin
         apb(`SBF_OFS_CFG1, 1, i);
         fire(4'h1, 0);
         chk("begin", mem_u.mem[16'h100 + 4 * i], 16'h6000);
         chk("cmd", mem_u.mem[16'h103 + 4 * i], 16'h1fe2);
         fire(4'h2, fl[i]);
         chk("status", mem_u.mem[16'h100 + 4 * i], ex[i]);
         chk("tag", mem_u.mem[16'h101 + 4 * i], 0);
      end
      chk("msg err", term_status, 16'hac08);
      apb(`SBF_OFS_LCMD, 0, 0); chk("lcmd", rd, 32'h11fe2);
      apb(`SBF_OFS_DPTR, 0, 0); chk("dptr", rd, 12);
      apb(`SBF_OFS_MASK1, 1, 2);
      apb(`SBF_OFS_MASK2, 1, 32'h1e);
      apb(`SBF_OFS_QPTR, 1, 32'h200);
      fire(4'h4, 20'h80010);
      fire(4'h4, 20'ha0000);
      fire(4'h4, 20'h00008);
      chk("qmsg", mem_u.mem[16'h200], 16'h0003);
      chk("qnon", mem_u.mem[16'h201], 16'h0010);
      apb(`SBF_OFS_QPTR, 0, 0); chk("qptr", rd, 32'h202);
      apb(`SBF_OFS_CFG1, 1, 3);
      fire(4'h8, 20'h05a24);
      chk("wdata", mem_u.mem[16'h10c], 16'h1fe2);
      chk("wid", mem_u.mem[16'h10d], 16'h5a24);
      // controller stop on error, then cleared by writing one
      apb(`SBF_OFS_CFG1, 1, 4);
      fire(4'h2, 20'h08000);
      apb(`SBF_OFS_FLAGS, 0, 0); chk("stopped", rd, 2);
      apb(`SBF_OFS_FLAGS, 1, 2);
      apb(`SBF_OFS_FLAGS, 0, 0); chk("unstopped", rd, 0);
      // time tag at the finest resolution counts once every 100 cycles
      apb(`SBF_OFS_CFG2, 1, 32'h0ab0);
      repeat (250) @(posedge pclk);
      apb(`SBF_OFS_TTAG, 0, 0); chk("ttag", rd, 2);
      wrap_up();
   end
endmodule // testbench
bind sbf_top sbf_checker chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .prdata, .msg_begin, .msg_end, .msg_chan_b, .mem_wr, .term_status);
`default_nettype wire
